//--- hdl/shadow_bank_top.sv
// Read-only bank of configuration values currently in force
// Contract
// - Reads answer in every controller state
// - Writes never change bank contents
// - Scrub bounds refresh only in config or low-power
// - Map, group, option, refresh words: config, low-power, halted
// - Lane maps reset to identity 0x76543210
// - Refresh interval resets to 0x00000100
// - Power group word 0 resets to 0x00020001
// - Chip-ID words reset values
// - Scrub low bound and path select reset zero
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "shadow_bank_map.svh"

module shadow_bank_top
(
    input logic clock,
    input logic clock_en,
    input logic sys_rst,
    input shadow_bank_pkg::ctl_state_t ctl_state,
    input shadow_bank_pkg::word_array_t cfg_prog,
    input shadow_bank_pkg::av_req_t av_req,
    output shadow_bank_pkg::av_rsp_t av_rsp,
    output shadow_bank_pkg::word_array_t cfg_now,
    output logic cfg_changed_q
);

    localparam int NUM = `NUM_WORDS;

    localparam logic [`ADDR_W-1:0] WORD_OFS [NUM] = '{
        `OFS_SCRUB_CTRL,
        `OFS_SCRUB_LOW,
        `OFS_SCRUB_HIGH,
        `OFS_CHIPSEL_W0,
        `OFS_CHIPSEL_W1,
        `OFS_CHIPSEL_W2,
        `OFS_CHIPSEL_W3,
        `OFS_CHIPID_W0,
        `OFS_CHIPID_W1,
        `OFS_CKE_MAP,
        `OFS_RESET_MAP,
        `OFS_CLOCK_MAP,
        `OFS_PWRGRP_W0,
        `OFS_PWRGRP_W1,
        `OFS_PWRGRP_W2,
        `OFS_PWRGRP_W3,
        `OFS_OPTIONS,
        `OFS_PATH_SEL,
        `OFS_RANK_ORDER,
        `OFS_REFRESH_INT
    };

    // Reset value of each word
    localparam logic [31:0] WORD_RST [NUM] = '{
        `RST_SCRUB_CTRL,
        `RST_ZERO,
        `RST_ZERO,
        `RST_ZERO,
        `RST_CHIPSEL_W1,
        `RST_CHIPSEL_W2,
        `RST_CHIPSEL_W3,
        `RST_CHIPID_W0,
        `RST_CHIPID_W1,
        `RST_IDENT_MAP,
        `RST_IDENT_MAP,
        `RST_IDENT_MAP,
        `RST_PWRGRP_W0,
        `RST_ZERO,
        `RST_ZERO,
        `RST_ZERO,
        `RST_ZERO,
        `RST_ZERO,
        `RST_IDENT_MAP,
        `RST_REFRESH_INT
    };

    // States in which each word may refresh
    localparam shadow_bank_pkg::update_class_t WORD_CLASS [NUM] = '{
        shadow_bank_pkg::upd_any,
        shadow_bank_pkg::upd_cfg_lp,
        shadow_bank_pkg::upd_cfg_lp,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt,
        shadow_bank_pkg::upd_cfg_lp_halt
    };

    logic [2:0] permit;
    logic [NUM-1:0] word_load;
    logic [NUM-1:0] word_chg;
    logic [NUM-1:0] word_pend;
    logic [NUM-1:0] word_hit;
    logic [2:0] cls_chg;
    logic [2:0] cls_pend;
    logic [4:0] hit_idx;
    logic [2:0] sticky_q;
    logic [2:0] sticky_d;
    logic [15:0] chg_count_q;
    logic [31:0] status_word;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;
    logic req_take;
    logic clear_hit;

    update_permit u_permit
    (
        .state(ctl_state),
        .permit(permit)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM; gi++)
        begin : g_word
            // Whole class loads in one edge, so a group never mixes
            assign word_load[gi] = |(permit & WORD_CLASS[gi]);
            assign word_pend[gi] = cfg_prog[gi] != cfg_now[gi];
            assign word_chg[gi] = word_load[gi] && word_pend[gi];
            assign word_hit[gi] = av_req.address == WORD_OFS[gi];

            // Only the update path loads, the bus has no way in
            shadow_word #(.RESET(WORD_RST[gi])) u_word
            (
                .clock(clock),
                .sys_rst(sys_rst),
                .clock_en(clock_en),
                .load(word_load[gi]),
                .d(cfg_prog[gi]),
                .q(cfg_now[gi])
            );
        end
    endgenerate

    // Per-class change and pending summaries
    always_comb
    begin
        cls_chg = 3'h0;
        cls_pend = 3'h0;
        for (int i = 0; i < NUM; i++)
        begin
            if (word_chg[i])
            begin
                cls_chg = cls_chg | WORD_CLASS[i];
            end
            if (word_pend[i])
            begin
                cls_pend = cls_pend | WORD_CLASS[i];
            end
        end
    end

    // Index of the addressed shadow word
    always_comb
    begin
        hit_idx = 5'h0;
        for (int i = 0; i < NUM; i++)
        begin
            if (word_hit[i])
            begin
                hit_idx = 5'(i);
            end
        end
    end

    always_comb
    begin
        status_word = 32'h0;
        status_word[`STAT_STATE_LSB +: 5] = ctl_state;
        status_word[`STAT_PERMIT_LSB +: 3] = permit;
        status_word[`STAT_PEND_LSB +: 3] = cls_pend;
        status_word[`STAT_COUNT_LSB +: 16] = chg_count_q;
    end

    // Read decode, no state gating anywhere on this path
    always_comb
    begin
        rd_data = 32'h0;
        rd_resp = `RESP_OKAY;
        if (av_req.address == `OFS_BANK_STATUS)
        begin
            rd_data = status_word;
        end
        else if (av_req.address == `OFS_UPD_STICKY)
        begin
            rd_data = {29'h0, sticky_q};
        end
        else if (|word_hit)
        begin
            rd_data = cfg_now[hit_idx];
        end
        else
        begin
            rd_resp = `RESP_DECODE;
        end
    end

    // A request is taken on the edge where waitrequest is still high
    assign req_take = (av_req.read || av_req.write) && av_rsp.waitrequest;

    assign clear_hit = req_take && av_req.write && av_req.byteenable[0]
        && (av_req.address == `OFS_UPD_STICKY);

    // Bus answer one edge after a request is taken
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            av_rsp.readdata <= 32'h0;
            av_rsp.response <= `RESP_OKAY;
            av_rsp.waitrequest <= 1'b1;
        end
        else if (clock_en)
        begin
            if (req_take)
            begin
                av_rsp.waitrequest <= 1'b0;
                av_rsp.response <= rd_resp;
                if (av_req.read)
                begin
                    av_rsp.readdata <= rd_data;
                end
                else
                begin
                    av_rsp.readdata <= 32'h0;
                end
            end
            else
            begin
                av_rsp.waitrequest <= 1'b1;
            end
        end
    end

    // Sticky change flags, a new change wins over a clear
    always_comb
    begin
        sticky_d = sticky_q;
        if (clear_hit)
        begin
            sticky_d = sticky_d & ~av_req.writedata[2:0];
        end
        sticky_d = sticky_d | cls_chg;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sticky_q <= 3'h0;
        end
        else if (clock_en)
        begin
            sticky_q <= sticky_d;
        end
    end

    // Count of edges on which any word took a new value
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            chg_count_q <= 16'h0;
        end
        else if (clock_en && (|cls_chg))
        begin
            chg_count_q <= chg_count_q + 16'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            cfg_changed_q <= 1'b0;
        end
        else if (clock_en)
        begin
            cfg_changed_q <= |cls_chg;
        end
    end

endmodule

//--- include/shadow_bank_map.svh
// Offsets, reset values, field positions and codes of the shadow bank
`ifndef SHADOW_BANK_MAP_SVH
`define SHADOW_BANK_MAP_SVH

`define NUM_WORDS 20
`define ADDR_W 16

`define OFS_SCRUB_CTRL 16'h1180
`define OFS_SCRUB_LOW 16'h1184
`define OFS_SCRUB_HIGH 16'h1188
`define OFS_CHIPSEL_W0 16'h11A0
`define OFS_CHIPSEL_W1 16'h11A4
`define OFS_CHIPSEL_W2 16'h11A8
`define OFS_CHIPSEL_W3 16'h11AC
`define OFS_CHIPID_W0 16'h11B0
`define OFS_CHIPID_W1 16'h11B4
`define OFS_CKE_MAP 16'h11C0
`define OFS_RESET_MAP 16'h11C4
`define OFS_CLOCK_MAP 16'h11C8
`define OFS_PWRGRP_W0 16'h11D0
`define OFS_PWRGRP_W1 16'h11D4
`define OFS_PWRGRP_W2 16'h11D8
`define OFS_PWRGRP_W3 16'h11DC
`define OFS_BANK_STATUS 16'h11E0
`define OFS_UPD_STICKY 16'h11E4
`define OFS_OPTIONS 16'h11F0
`define OFS_PATH_SEL 16'h11F4
`define OFS_RANK_ORDER 16'h11F8
`define OFS_REFRESH_INT 16'h1200

`define RST_SCRUB_CTRL 32'h0FFF_FF00
`define RST_ZERO 32'h0000_0000
`define RST_CHIPSEL_W1 32'h0000_0004
`define RST_CHIPSEL_W2 32'h0020_0010
`define RST_CHIPSEL_W3 32'h0080_0040
`define RST_CHIPID_W0 32'h2000_1000
`define RST_CHIPID_W1 32'h0000_4000
`define RST_IDENT_MAP 32'h7654_3210
`define RST_PWRGRP_W0 32'h0002_0001
`define RST_REFRESH_INT 32'h0000_0100

`define STAT_STATE_LSB 0
`define STAT_PERMIT_LSB 8
`define STAT_PEND_LSB 12
`define STAT_COUNT_LSB 16

`define RESP_OKAY 2'h0
`define RESP_DECODE 2'h3

`endif

//--- include/shadow_bank_pkg.sv
// Types shared by the shadow bank modules
`include "shadow_bank_map.svh"

package shadow_bank_pkg;

    typedef enum logic [4:0] {
        config_state = 5'h01,
        ready_state = 5'h02,
        low_power_state = 5'h04,
        halted_traffic_state = 5'h08,
        transition_state = 5'h10
    } ctl_state_t;

    typedef enum logic [2:0] {
        upd_any = 3'h1,
        upd_cfg_lp = 3'h2,
        upd_cfg_lp_halt = 3'h4
    } update_class_t;

    typedef logic [31:0] word_t;
    typedef word_t [`NUM_WORDS-1:0] word_array_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [`ADDR_W-1:0] address;
        word_t writedata;
        logic [3:0] byteenable;
    } av_req_t;

    typedef struct packed {
        word_t readdata;
        logic [1:0] response;
        logic waitrequest;
    } av_rsp_t;

endpackage

//--- hdl/update_permit.sv
// Which update classes may refresh in the present controller state
`timescale 1ns/1ps

module update_permit
(
    input shadow_bank_pkg::ctl_state_t state,
    output logic [2:0] permit
);

    always_comb
    begin
        permit = 3'h0;
        case (state)
            shadow_bank_pkg::config_state:
            begin
                permit = 3'h7;
            end
            shadow_bank_pkg::low_power_state:
            begin
                permit = 3'h7;
            end
            shadow_bank_pkg::halted_traffic_state:
            begin
                permit = 3'h5;
            end
            default:
            begin
                permit = 3'h1;
            end
        endcase
    end

endmodule

//--- hdl/shadow_word.sv
// One current-value word with its own reset value
`timescale 1ns/1ps

module shadow_word
#(
    parameter logic [31:0] RESET = 32'h0000_0000
)
(
    input logic clock,
    input logic sys_rst,
    input logic clock_en,
    input logic load,
    input logic [31:0] d,
    output logic [31:0] q
);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            q <= RESET;
        end
        else if (clock_en && load)
        begin
            q <= d;
        end
    end

endmodule

//--- testbench/shadow_bank_top_props.sv
// Port checker of the shadow bank
`timescale 1ns/1ps
`include "shadow_bank_map.svh"

module shadow_bank_top_props
(
    input logic clock,
    input logic clock_en,
    input logic sys_rst,
    input shadow_bank_pkg::ctl_state_t ctl_state,
    input shadow_bank_pkg::word_array_t cfg_prog,
    input shadow_bank_pkg::av_req_t av_req,
    input shadow_bank_pkg::av_rsp_t av_rsp,
    input shadow_bank_pkg::word_array_t cfg_now,
    input logic cfg_changed_q
);
    logic taken;
    logic idle_s;
    logic lp_s;
    logic halt_s;
    logic cfg_s;
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    assign taken = (av_req.read | av_req.write) & av_rsp.waitrequest
        & clock_en;
    assign cfg_s = ctl_state[0] & clock_en;
    assign lp_s = ctl_state[2] & clock_en;
    assign halt_s = ctl_state[3] & clock_en;
    assign idle_s = (ctl_state[1] | ctl_state[4]) & clock_en;

    answer_next_a: assert property (taken |=> !av_rsp.waitrequest)
        else $error("request not answered one cycle later");
    answer_once_a: assert property (!av_rsp.waitrequest && clock_en
        |=> av_rsp.waitrequest)
        else $error("answer held longer than one cycle");
    read_data_a: assert property (taken && av_req.read
        && av_req.address == 16'h1200
        |=> av_rsp.readdata == $past(cfg_now[19]))
        else $error("read data differs from value in force");
    idle_hold_a: assert property (idle_s |=> $stable(cfg_now[19:1]))
        else $error("word refreshed in ready or transition state");
    scrub_halt_a: assert property (halt_s |=> $stable(cfg_now[2:1]))
        else $error("scrub bound refreshed while halted");
    cfg_copy_a: assert property (cfg_s |=> cfg_now == $past(cfg_prog))
        else $error("config state did not copy programmed words");
    lp_copy_a: assert property (lp_s |=> cfg_now == $past(cfg_prog))
        else $error("low power state did not copy programmed words");
    halt_copy_a: assert property (halt_s
        |=> cfg_now[19:3] == $past(cfg_prog[19:3]))
        else $error("halted state did not copy map words");
    reset_val_a: assert property (disable iff (1'b0) sys_rst
        |=> cfg_now[19] == `RST_REFRESH_INT
        && cfg_now[12] == `RST_PWRGRP_W0 && cfg_now[18] == `RST_IDENT_MAP)
        else $error("wrong value after reset");

    cover property (taken && av_req.write);
    cover property (taken && av_req.read && ctl_state[3]);
    cover property (cfg_changed_q);
endmodule

//--- testbench/shadow_bank_top_tb.sv
// Bus-level testbench of the shadow bank
`timescale 1ns/1ps

module shadow_bank_top_tb;
    localparam logic [15:0] OFS [14] = '{16'h1184, 16'h1188, 16'h11A4,
        16'h11A8, 16'h11AC, 16'h11B0, 16'h11B4, 16'h11C0, 16'h11C4,
        16'h11C8, 16'h11D0, 16'h11F4, 16'h11F8, 16'h1200};
    localparam logic [31:0] RST [14] = '{32'h0000_0000, 32'h0000_0000,
        32'h0000_0004, 32'h0020_0010, 32'h0080_0040, 32'h2000_1000,
        32'h0000_4000, 32'h7654_3210, 32'h7654_3210, 32'h7654_3210,
        32'h0002_0001, 32'h0000_0000, 32'h7654_3210, 32'h0000_0100};
    logic clock;
    logic clock_en;
    logic sys_rst;
    shadow_bank_pkg::ctl_state_t ctl_state;
    shadow_bank_pkg::word_array_t cfg_prog;
    shadow_bank_pkg::av_req_t req;
    shadow_bank_pkg::av_rsp_t rsp;
    shadow_bank_pkg::word_array_t cfg_now;
    logic chg;
    int err_total;
    int cmp_count;

    shadow_bank_top u_shadow_bank_top (.clock(clock), .clock_en(clock_en),
        .sys_rst(sys_rst), .ctl_state(ctl_state), .cfg_prog(cfg_prog),
        .av_req(req), .av_rsp(rsp), .cfg_now(cfg_now), .cfg_changed_q(chg));

    task automatic tally_and_finish();
        if (err_total == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk_rsp(input logic [1:0] g, input logic [1:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %0t rsp %h exp %h", $time, g, e);
        end
    endtask

    // One bus access, entered and left just after a rising edge
    task automatic acc(input logic wr, input logic [15:0] a,
        input logic [31:0] wd, output logic [31:0] d, output logic [1:0] rs);
        int n;
        n = 0;
        req.read <= !wr;
        req.write <= wr;
        req.address <= a;
        req.writedata <= wd;
        req.byteenable <= 4'hF;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (rsp.waitrequest !== 1'b0 && n < 40);
        if (rsp.waitrequest !== 1'b0)
        begin
            err_total++;
            tally_and_finish();
        end
        d = rsp.readdata;
        rs = rsp.response;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e,
        input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] rs;
        acc(1'b0, a, 32'h0000_0000, d, rs);
        chk(d, e);
        chk_rsp(rs, er);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial
    begin
        logic [31:0] v;
        logic [31:0] lo;
        logic [31:0] ri;
        logic [31:0] d;
        logic [1:0] rs;
        logic [4:0] st;
        err_total = 0;
        cmp_count = 0;
        clock_en = 1'b1;
        sys_rst = 1'b1;
        ctl_state = shadow_bank_pkg::ready_state;
        cfg_prog = '0;
        req = '0;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        chk(cfg_now[0], 32'h0FFF_FF00);
        @(posedge clock);
        foreach (OFS[k]) rd(OFS[k], RST[k], 2'h0);
        acc(1'b1, 16'h1200, 32'hDEAD_BEEF, d, rs);
        chk_rsp(rs, 2'h0);
        rd(16'h1200, 32'h0000_0100, 2'h0);
        rd(16'h1190, 32'h0000_0000, 2'h3);
        lo = 32'h0000_0000;
        ri = 32'h0000_0100;
        // Ready, low power, halted, transition, config in turn
        for (int i = 0; i < 5; i++)
        begin
            v = 32'h5A00_0000 + i;
            st = 5'h01 << ((i + 1) % 5);
            ctl_state <= shadow_bank_pkg::ctl_state_t'(st);
            cfg_prog <= {20{v}};
            repeat (2) @(posedge clock);
            chk({31'h0, chg}, 32'h0000_0001);
            if (st[0] | st[2])
                lo = v;
            if (st[0] | st[2] | st[3])
                ri = v;
            rd(16'h1184, lo, 2'h0);
            rd(16'h1200, ri, 2'h0);
            rd(16'h1180, v, 2'h0);
            acc(1'b1, 16'h1188, 32'h0000_0FFF, d, rs);
            rd(16'h1188, lo, 2'h0);
            chk(cfg_now[19], ri);
        end
        rd(16'h11E0, 32'h0006_0701, 2'h0);
        rd(16'h11E4, 32'h0000_0007, 2'h0);
        acc(1'b1, 16'h11E4, 32'h0000_0007, d, rs);
        chk_rsp(rs, 2'h0);
        rd(16'h11E4, 32'h0000_0000, 2'h0);
        tally_and_finish();
    end
endmodule

bind shadow_bank_top shadow_bank_top_props u_shadow_bank_top_props (
    .clock(clock), .clock_en(clock_en), .sys_rst(sys_rst),
    .ctl_state(ctl_state), .cfg_prog(cfg_prog), .av_req(av_req),
    .av_rsp(av_rsp), .cfg_now(cfg_now), .cfg_changed_q(cfg_changed_q));
